// ---- logic/mehc_top.sv ----
// Extended header element parser with AXI4-Lite register access
//
// Added by the designer: the register addresses and register access over AXI4-Lite.
`include "mehc_regs.svh"
module mehc_top
  import mehc_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [3:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [3:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        hdr_start,
  input  wire logic [7:0]  hdr_len,
  input  wire logic        hdr_is_frag,
  input  wire logic        byte_valid,
  input  wire logic [7:0]  byte_data,
  output logic             byte_ready,
  output logic             priv_valid,
  output logic [39:0]      priv_data,
  output logic             parse_done,
  output logic             malformed,
  output logic [47:0]      frag_elem
);
  mehc_state_t state;
  logic [7:0]  pos;
  logic [3:0]  etype;
  logic [7:0]  elen;
  logic [7:0]  vcnt;
  logic [39:0] vbuf;
  logic [31:0] ctrl;
  logic [7:0]  req_amt;
  logic        req_seen;
  logic [7:0]  phs_dn;
  logic [7:0]  phs_up;
  logic [7:0]  ugs;
  logic        phs_up_on;
  logic        phs_dn_on;
  logic [15:0] ack_sid;
  logic        ack_seen;
  logic [1:0]  frag_bits;
  logic        aw_held;
  logic        w_held;
  logic [3:0]  aw_q;
  logic [31:0] w_q;
  logic        elem_end;
  logic        value_byte;
  logic        in_byte;
  logic [7:0]  next_pos;

  // Whole element seen once its last value byte arrives
  function automatic logic is_last(input logic [7:0] cnt,
                                   input logic [7:0] len);
    is_last = (cnt + 8'h1 == len);
  endfunction

  assign in_byte  = byte_valid && byte_ready;
  assign next_pos = pos + 8'h1;
  assign value_byte = in_byte && state == MEHC_VAL;
  assign elem_end = value_byte && is_last(vcnt, elen);

  // Element walker; bounded by header length, never beyond 240
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= MEHC_DONE;
      pos   <= 8'h0;
      etype <= 4'h0;
      elen  <= 8'h0;
      vcnt  <= 8'h0;
    end else if (hdr_start) begin
      pos   <= 8'h0;
      vcnt  <= 8'h0;
      if (hdr_len == 8'h0 || hdr_len > `MEHC_EHDR_MAX) begin
        state <= MEHC_BAD;
      end else begin
        state <= MEHC_HDR;
      end
    end else if (in_byte) begin
      pos <= next_pos;
      case (state)
        MEHC_HDR: begin
          etype <= byte_data[7:4];
          elen  <= {4'h0, byte_data[3:0]};
          vcnt  <= 8'h0;
          if (pos + {4'h0, byte_data[3:0]} >= hdr_len) begin
            state <= MEHC_BAD;
          end else if (byte_data[3:0] == 4'h0) begin
            // Padding and empty elements are stepped over
            state <= (next_pos == hdr_len) ? MEHC_DONE : MEHC_HDR;
          end else begin
            state <= MEHC_VAL;
          end
        end
        MEHC_VAL: begin
          vcnt <= vcnt + 8'h1;
          if (etype == `MEHC_T_ESC && vcnt == 8'h1 &&
              byte_data != elen - 8'h2) begin
            // Escape declares its own inner length; mismatch is overrun
            state <= MEHC_BAD;
          end else if (is_last(vcnt, elen)) begin
            // Unknown types fall here too and walking continues
            state <= (next_pos == hdr_len) ? MEHC_DONE : MEHC_HDR;
          end
        end
        default: state <= state;
      endcase
    end
  end

  assign byte_ready = (state == MEHC_HDR) || (state == MEHC_VAL);

  // Value bytes shift in so the element ends with its bytes in order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      vbuf <= 40'h0;
    end else if (value_byte) begin
      vbuf <= {vbuf[31:0], byte_data};
    end
  end

  // Decoded results; reserved and extended types touch none of them
  always_ff @(posedge aclk) begin
    if (!aresetn || hdr_start) begin
      req_amt   <= 8'h0;
      req_seen  <= 1'b0;
      ack_sid   <= 16'h0;
      ack_seen  <= 1'b0;
      phs_dn    <= 8'h0;
      phs_up    <= 8'h0;
      ugs       <= 8'h0;
      phs_dn_on <= 1'b0;
      phs_up_on <= 1'b0;
      frag_bits <= 2'b00;
    end else if (elem_end) begin
      case ({etype, elen[3:0]})
        {`MEHC_T_REQ, 4'h3}: begin
          req_amt  <= vbuf[15:8];
          req_seen <= 1'b1;
        end
        {`MEHC_T_ACK, 4'h2}: begin
          ack_sid  <= {vbuf[7:0], byte_data};
          ack_seen <= 1'b1;
        end
        {`MEHC_T_BPUP, 4'h4}: begin
          req_amt  <= vbuf[15:8];
          req_seen <= 1'b1;
        end
        {`MEHC_T_BPUP, 4'h5}: begin
          if (hdr_is_frag) begin
            req_amt   <= vbuf[7:0];
            req_seen  <= 1'b1;
            frag_bits <= byte_data[5:4];
          end
        end
        {`MEHC_T_SFDN, 4'h1}: begin
          phs_dn    <= byte_data;
          phs_dn_on <= byte_data != 8'h0;
        end
        {`MEHC_T_SFUP, 4'h1}: begin
          phs_up    <= byte_data;
          phs_up_on <= byte_data != 8'h0;
        end
        {`MEHC_T_SFUP, 4'h2}: begin
          phs_up    <= vbuf[7:0];
          ugs       <= byte_data;
          phs_up_on <= vbuf[7:0] != 8'h0;
        end
        default: req_seen <= req_seen;
      endcase
    end
  end

  // Privacy bytes handed on unchanged for the privacy engine
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      priv_valid <= 1'b0;
      priv_data  <= 40'h0;
    end else begin
      priv_valid <= 1'b0;
      if (elem_end && (etype == `MEHC_T_BPUP || etype == `MEHC_T_BPDN)) begin
        if (elen == 8'h4) begin
          priv_valid <= 1'b1;
          priv_data  <= {8'h0, vbuf[23:0], byte_data};
        end else if (elen == 8'h5 && etype == `MEHC_T_BPUP && hdr_is_frag) begin
          priv_valid <= 1'b1;
          priv_data  <= {vbuf[31:0], byte_data};
        end
      end
    end
  end

  // Status pins follow the walker state, registered
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      parse_done <= 1'b0;
      malformed  <= 1'b0;
    end else begin
      parse_done <= state == MEHC_DONE;
      malformed  <= state == MEHC_BAD;
    end
  end

  // Fragment builder driven from control register fields
  mehc_frag_gen u_frag (
    .aclk    (aclk),
    .aresetn (aresetn),
    .start   (ctrl[31]),
    .first   (ctrl[30]),
    .last    (ctrl[29]),
    .key_seq (ctrl[27:24]),
    .priv_en (ctrl[23]),
    .toggle  (ctrl[22]),
    .sid     (ctrl[21:8]),
    .req     (ctrl[7:0]),
    .elem    (frag_elem)
  );

  // AXI write: address and data taken in either order, then response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held  <= 1'b0;
      aw_q    <= 4'h0;
      w_q     <= 32'h0;
    end else if (aw_held && w_held) begin
      aw_held <= 1'b0;
      w_held  <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_q    <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_q    <= s_axi_wdata;
      end
    end
  end

  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready  = !w_held && !s_axi_bvalid;

  // Control register; start bit self-clears so each write builds once
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl         <= `MEHC_CTRL_RST;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= 2'b00;
    end else begin
      ctrl[31] <= 1'b0;
      if (aw_held && w_held) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (aw_q[3:2] == 2'b00) ? 2'b00 : 2'b10;
        if (aw_q[3:2] == 2'b00 && &s_axi_wstrb) begin
          ctrl <= w_q;
        end
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // AXI read: one cycle to answer, unmapped returns slave error
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0;
      s_axi_rresp  <= 2'b00;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= 2'b00;
      case (s_axi_araddr)
        `MEHC_ADDR_CTRL:   s_axi_rdata <= {1'b0, ctrl[30:0]};
        // Service id sits at [19:4] so the one-hot state fits below it
        `MEHC_ADDR_STATUS: s_axi_rdata <= {12'h0, ack_sid, state};
        `MEHC_ADDR_REQ:    s_axi_rdata <= {13'h0, ack_seen, frag_bits,
                                           req_seen, 7'h0, req_amt};
        `MEHC_ADDR_PHS:    s_axi_rdata <= {6'h0, phs_up_on, phs_dn_on,
                                           ugs, phs_up, phs_dn};
        default: begin
          s_axi_rdata <= 32'h0;
          s_axi_rresp <= 2'b10;
        end
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  assign s_axi_arready = !s_axi_rvalid;
endmodule

// ---- logic/mehc_regs.svh ----
// Constants for the extended header element codec
// Overview of operation
// - Type 0 is zero-length padding, skipped
// - Type 1 length 3: minislots then service id
// - Type 2 length 2: acknowledgment service id
// - Type 3 length 4 passes privacy bytes
// - Type 3 length 5 only in fragment header
// - Type 4 length 4 gives downstream privacy
// - Type 5 length 1: downstream suppression byte
// - Type 6 length 1: upstream suppression byte
// - Type 6 length 2: suppression then grant sync
// - Types 7 to 14 have no function
// - Type 15: extended type, length, then value
// - Extract request from types 1 and 3
// - Fragment byte one: key sequence, version 1
// - Then privacy enable and toggle flags
// - Then 14-bit service id, 8-bit request
// - Sender drives two reserved bits zero
// - First and last flags mark end fragments
// - Fragment sequence advances once per fragment
// - Service flow value: suppression first, sync second
// - First byte: type and length; skip unknown
// - Ignore reserved and extended contents, continue
// - Header length 1 to 240, walker bounded
// - Suppression zero means none, else index
`ifndef MEHC_REGS_SVH
`define MEHC_REGS_SVH
`define MEHC_ADDR_CTRL     4'h0
`define MEHC_ADDR_STATUS   4'h4
`define MEHC_ADDR_REQ      4'h8
`define MEHC_ADDR_PHS      4'hC
`define MEHC_CTRL_RST      32'h0000_0000
`define MEHC_EHDR_MAX      8'hF0
`define MEHC_T_PAD         4'h0
`define MEHC_T_REQ         4'h1
`define MEHC_T_ACK         4'h2
`define MEHC_T_BPUP        4'h3
`define MEHC_T_BPDN        4'h4
`define MEHC_T_SFDN        4'h5
`define MEHC_T_SFUP        4'h6
`define MEHC_T_ESC         4'hF
`define MEHC_FRAG_VER      4'h1
`endif

// ---- logic/mehc_pkg.sv ----
// Types shared by the extended header codec
package mehc_pkg;
  typedef enum logic [3:0] {
    MEHC_HDR  = 4'b0001,
    MEHC_VAL  = 4'b0010,
    MEHC_DONE = 4'b0100,
    MEHC_BAD  = 4'b1000
  } mehc_state_t;
endpackage

// ---- logic/mehc_frag_gen.sv ----
// Builds the six-byte fragmentation element for one fragment
`include "mehc_regs.svh"
module mehc_frag_gen
  import mehc_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        start,
  input  wire logic        first,
  input  wire logic        last,
  input  wire logic [3:0]  key_seq,
  input  wire logic        priv_en,
  input  wire logic        toggle,
  input  wire logic [13:0] sid,
  input  wire logic [7:0]  req,
  output logic      [47:0] elem
);
  logic [3:0] seq;

  // Sequence advances once per fragment; first fragment keeps its seed
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      seq <= 4'h0;
    end else if (start && !first) begin
      seq <= seq + 4'h1;
    end
  end

  // Fragment element packed in wire order, first byte in top bits
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      elem <= 48'h0;
    end else if (start) begin
      elem <= {`MEHC_T_BPUP, 4'h5,
               key_seq, `MEHC_FRAG_VER,
               priv_en, toggle, sid,
               req,
               2'b00,
               first, last,
               first ? seq : seq + 4'h1};
    end
  end
endmodule

// ---- tb/mehc_top_monitor.sv ----
// Port-level checks for the header element codec
`include "mehc_regs.svh"
module mehc_top_monitor (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic [3:0]  s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        hdr_start,
  input wire logic [7:0]  hdr_len,
  input wire logic        byte_ready,
  input wire logic        priv_valid,
  input wire logic        parse_done,
  input wire logic        malformed,
  input wire logic [47:0] frag_elem
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Read channel answers next cycle and holds
  a_read_answer: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("late rvalid");
  a_read_hold: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata dropped");
  a_read_unmapped: assert property (s_axi_arvalid && s_axi_arready &&
    s_axi_araddr[1:0] != 2'h0 |=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0)
    else $error("unmapped read not refused");
  // Header length outside 1..240 must be flagged quickly
  a_len_check: assert property (
    hdr_start && (hdr_len == 8'h00 || hdr_len > `MEHC_EHDR_MAX)
    |-> ##[1:3] malformed) else $error("bad length accepted");
  a_done_excl: assert property (
    !(parse_done && malformed)) else $error("done and malformed together");
  a_walk_stop: assert property (
    $rose(malformed) |-> !byte_ready) else $error("walker kept going");
  a_priv_pulse: assert property (
    priv_valid |=> !priv_valid) else $error("privacy pulse too long");
  // Built element has fixed type, version and zero reserved bits
  a_frag_fixed: assert property (
    frag_elem != 48'h0 |-> frag_elem[47:40] == 8'h35 &&
    frag_elem[35:32] == `MEHC_FRAG_VER && frag_elem[7:6] == 2'h0)
    else $error("fragment element fields wrong");
endmodule

bind mehc_top mehc_top_monitor u_mon (.aclk, .aresetn, .s_axi_araddr,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
  .s_axi_rready, .hdr_start, .hdr_len, .byte_ready, .priv_valid, .parse_done,
  .malformed, .frag_elem);

// ---- tb/mehc_peer.sv ----
// Far-side sender model streaming extended header bytes
module mehc_peer (
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       go,
  input  wire logic       slow,
  input  wire logic [7:0] hb [0:23],
  input  wire logic [4:0] n,
  input  wire logic       byte_ready,
  output logic            byte_valid,
  output logic [7:0]      byte_data
);
  logic [4:0] idx;
  logic       gap;
  // Idle data is inverted so a stale byte never looks valid
  assign byte_valid = (idx < n) && !gap;
  assign byte_data  = byte_valid ? hb[idx] : ~hb[idx];
  // Slow mode stalls one cycle after each byte taken
  always_ff @(posedge aclk) begin
    if (!aresetn || go) begin
      idx <= 5'h00;
      gap <= 1'h0;
    end else if (byte_valid && byte_ready) begin
      idx <= idx + 5'h01;
      gap <= slow;
    end else begin
      gap <= 1'h0;
    end
  end
endmodule

// ---- tb/mehc_top_tb_top.sv ----
// Self-checking bench for the header element codec
`include "mehc_regs.svh"
module mehc_top_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
  logic        s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
  logic        s_axi_arready, s_axi_rvalid, s_axi_rready, hdr_start;
  logic        hdr_is_frag, byte_valid, byte_ready, priv_valid, parse_done;
  logic        malformed, go, slow;
  logic [3:0]  s_axi_awaddr, s_axi_araddr, s_axi_wstrb, sq;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [7:0]  hdr_len, byte_data;
  logic [7:0]  hb [0:23];
  logic [4:0]  n;
  logic [39:0] priv_data, pv_d;
  logic [47:0] frag_elem;
  int          fails, checks_done, pv_n;

  mehc_top uut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .hdr_start, .hdr_len, .hdr_is_frag, .byte_valid, .byte_data, .byte_ready,
    .priv_valid, .priv_data, .parse_done, .malformed, .frag_elem);
  mehc_peer peer (.aclk, .aresetn, .go, .slow, .hb, .n, .byte_ready,
    .byte_valid, .byte_data);

  initial begin
    aclk = 1'h0;
    forever #10 aclk = ~aclk;
  end
  // Privacy pulses are counted, so a missing or extra one shows
  always @(posedge aclk) if (priv_valid) begin
    pv_n <= pv_n + 1;
    pv_d <= priv_data;
  end

  task conclude;
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task chk(input string nm, input logic [47:0] e, input logic [47:0] g);
    checks_done++;
    if (g !== e) begin
      fails++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Write: address and data offered together, each dropped when taken
  task wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
    int k;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    k = 0;
    do begin
      @(posedge aclk);
      k++;
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (!s_axi_bvalid && k < 60);
    if (k == 60) begin fails++; conclude; end
    chk("bresp", 48'(er), 48'(s_axi_bresp));
  endtask
  task rd(input logic [3:0] a, input logic [31:0] ed, input logic [1:0] er);
    int k;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    k = 0;
    do begin
      @(posedge aclk);
      k++;
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
    end while (!s_axi_rvalid && k < 60);
    if (k == 60) begin fails++; conclude; end
    chk("rdata", 48'(ed), 48'(s_axi_rdata));
    chk("rresp", 48'(er), 48'(s_axi_rresp));
  endtask
  // One header: start pulse, byte stream, then wait for the verdict
  task hdr(input logic [7:0] len, input logic frag, input logic bad,
           input logic [7:0] q[$]);
    int k;
    foreach (q[i]) hb[i] = q[i];
    n <= 5'(q.size());
    hdr_len <= len;
    hdr_is_frag <= frag;
    hdr_start <= 1'h1;
    go <= 1'h1;
    @(posedge aclk);
    hdr_start <= 1'h0;
    go <= 1'h0;
    repeat (2) @(posedge aclk);
    k = 0;
    while (!parse_done && !malformed && k < 200) begin
      @(posedge aclk);
      k++;
    end
    if (k == 200) begin fails++; conclude; end
    chk("malformed", 48'(bad), 48'(malformed));
  endtask
  // Build one fragment element; st is the expected sequence step
  task fb(input logic [31:0] c, input logic [1:0] fl, input logic [3:0] st);
    wr(`MEHC_ADDR_CTRL, c, 2'h0);
    repeat (4) @(posedge aclk);
    if (st == 4'h0) sq = frag_elem[3:0];
    chk("frag", {40'h35_A1AA_BC40, 2'h0, fl, sq + st}, frag_elem);
  endtask

  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 4'h0;
    {s_axi_arvalid, s_axi_rready, hdr_start, hdr_is_frag} = 4'h0;
    {go, slow, n, hdr_len, sq} = 19'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 40'h0;
    s_axi_wstrb = 4'hF;
    fails = 0;
    checks_done = 0;
    pv_n = 0;
    foreach (hb[i]) hb[i] = 8'h00;
    repeat (5) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    rd(`MEHC_ADDR_CTRL, `MEHC_CTRL_RST, 2'h0);
    hdr(8'h14, 1'h0, 1'h0, '{8'h00, 8'h13, 8'hAA, 8'h12, 8'h34, 8'h22, 8'h56,
      8'h78, 8'h72, 8'h01, 8'h02, 8'hF3, 8'h09, 8'h01, 8'hEE, 8'h62, 8'h05,
      8'h81, 8'h51, 8'h07});
    rd(`MEHC_ADDR_REQ, 32'h0004_80AA, 2'h0);
    rd(`MEHC_ADDR_STATUS, 32'h0005_6784, 2'h0);
    rd(`MEHC_ADDR_PHS, 32'h0381_0507, 2'h0);
    hdr(8'h04, 1'h0, 1'h0, '{8'h61, 8'h09, 8'h51, 8'h00});
    rd(`MEHC_ADDR_PHS, 32'h0200_0900, 2'h0);
    slow <= 1'h1;
    hdr(8'h0A, 1'h0, 1'h0, '{8'h34, 8'h11, 8'h22, 8'h33, 8'h44, 8'h44,
      8'hA5, 8'h5A, 8'h0F, 8'hF0});
    chk("priv_cnt", 48'h2, 48'(pv_n));
    chk("priv", 48'h00A5_5A0F_F0, 48'(pv_d[31:0]));
    rd(`MEHC_ADDR_REQ, 32'h0000_8022, 2'h0);
    hdr(8'h06, 1'h1, 1'h0, '{8'h35, 8'hA1, 8'hAA, 8'hBC, 8'h40, 8'h25});
    chk("priv", 48'hA1_AABC_4025, 48'(pv_d));
    rd(`MEHC_ADDR_REQ, 32'h0002_8040, 2'h0);
    hdr(8'h06, 1'h0, 1'h0, '{8'h35, 8'hA1, 8'hAA, 8'hBC, 8'h40, 8'h25});
    chk("priv_cnt", 48'h3, 48'(pv_n));
    slow <= 1'h0;
    hdr(8'h03, 1'h0, 1'h1, '{8'h13, 8'h01, 8'h02});
    hdr(8'h04, 1'h0, 1'h1, '{8'hF3, 8'h09, 8'h02, 8'hEE});
    hdr(8'h00, 1'h0, 1'h1, '{});
    hdr(8'hF1, 1'h0, 1'h1, '{});
    fb(32'hCAAA_BC40, 2'h2, 4'h0);
    rd(`MEHC_ADDR_CTRL, 32'h4AAA_BC40, 2'h0);
    fb(32'h8AAA_BC40, 2'h0, 4'h1);
    fb(32'hAAAA_BC40, 2'h1, 4'h2);
    wr(4'h4, 32'h0000_0001, 2'h2);
    rd(4'h2, 32'h0, 2'h2);
    conclude;
  end
endmodule
